// >>> verilog/fspg_pkg.sv
// Purpose: Shared constants and types for the flash sector program guard
// Assumes: 16-bit CPU address space, flash array sits at its top
// Notes:   Guard keys are arbitrary values
package fspg_pkg;

    // Sector layout
    localparam int          SECTOR_KB      = 4;
    localparam logic [15:0] SECTOR0_BASE   = 16'hF000;
    localparam logic [15:0] SECTOR1_BASE   = 16'hE000;
    localparam logic [16:0] ADDR_SPACE_TOP = 17'h1_0000;
    localparam int          FLASH_KB_DFLT  = 60;

    // Unlock keys for the register access guard (arbitrary values)
    localparam logic [7:0]  GUARD_KEY1     = 8'h5A;
    localparam logic [7:0]  GUARD_KEY2     = 8'hC3;

    // Option byte field holding read-out protection (1 = protected)
    localparam int          OPT_PROTECT_BIT = 0;
    localparam logic        PROTECT_RST     = 1'b1;

    typedef enum logic [1:0]
    {
        OP_PROG_BYTE    = 2'h0,
        OP_ERASE_SECTOR = 2'h1,
        OP_ERASE_ALL    = 2'h2,
        OP_PROG_OPTION  = 2'h3
    } fspg_op_type;

    typedef enum logic [1:0]
    {
        MODE_NONE                 = 2'h0,
        MODE_EXT_TOOL             = 2'h1,
        MODE_IN_CIRCUIT_PROG      = 2'h2,
        MODE_IN_APPLICATION_PROG  = 2'h3
    } fspg_mode_type;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_ISSUE = 2'b11
    } fspg_state_type;

    typedef struct packed
    {
        fspg_op_type op;
        logic [15:0] addr;
        logic [7:0]  data;
    } fspg_req_type;

    typedef struct packed
    {
        fspg_op_type op;
        logic [1:0]  sector;
        logic [15:0] addr;
        logic [7:0]  data;
    } fspg_cmd_type;

endpackage

// >>> verilog/fspg_sector_decode.sv
// Purpose: Maps a flash address to its sector number
// Assumes: Array occupies the top FLASH_KB kilobytes of the address space
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module fspg_sector_decode #(
    parameter int FLASH_KB = fspg_pkg::FLASH_KB_DFLT
) (
    // Address in
    input  wire logic [15:0] addr,
    // Decode out
    output logic             hit,
    output logic [1:0]       sector
);

    localparam logic [16:0] ARRAY_BYTES = 17'(FLASH_KB * 1024);
    localparam logic [16:0] ARRAY_BASE  = fspg_pkg::ADDR_SPACE_TOP - ARRAY_BYTES;

    always_comb
    begin
        hit = ({1'b0, addr} >= ARRAY_BASE);
        // Top two sectors are fixed, remainder is sector 2
        if (addr >= fspg_pkg::SECTOR0_BASE)
            sector = 2'h0;
        else if (addr >= fspg_pkg::SECTOR1_BASE && FLASH_KB > fspg_pkg::SECTOR_KB)
            sector = 2'h1;
        else
            sector = 2'h2;
    end

endmodule
`default_nettype wire

// >>> verilog/fspg_guard.sv
// Purpose: Gates program/erase requests to the flash array by mode and protection
// Assumes: Array macro takes one command per ARR_START and pulses ARR_DONE
// Notes:   One unlock admits at most one request
`timescale 1ns/100ps
`default_nettype none
module fspg_guard #(
    parameter int FLASH_KB = fspg_pkg::FLASH_KB_DFLT
) (
    // Clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   RSTN,
    input  wire logic                   CE,
    // Mode and option inputs
    input  wire fspg_pkg::fspg_mode_type MODE,
    input  wire logic                   READOUT_PROTECT_NV,
    // Register access guard key writes
    input  wire logic                   GUARD_WR,
    input  wire logic [7:0]             GUARD_KEY,
    // Program/erase requests
    input  wire logic                   REQ_VALID,
    input  wire fspg_pkg::fspg_req_type REQ,
    output logic                        REQ_READY,
    output logic                        REQ_DONE,
    output logic                        REQ_REFUSED,
    // Array command port
    output logic                        ARR_START,
    output fspg_pkg::fspg_cmd_type      ARR_CMD,
    input  wire logic                   ARR_DONE,
    // Status
    output logic                        UNLOCKED,
    output logic                        PROTECTED,
    output logic                        EXT_READ_EN
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    logic       dec_hit;
    logic [1:0] dec_sector;

    fspg_sector_decode #(.FLASH_KB(FLASH_KB)) u_dec (
        .addr   (REQ.addr),
        .hit    (dec_hit),
        .sector (dec_sector)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    fspg_pkg::fspg_state_type state_r, state_nxt;
    fspg_pkg::fspg_cmd_type   cmd_r, cmd_nxt, pend_cmd_r, pend_cmd_nxt;
    logic pend_r, pend_nxt;
    logic key1_r, key1_nxt, unlock_r, unlock_nxt;
    logic prot_r, prot_nxt, loaded_r, loaded_nxt;
    logic start_r, start_nxt, done_r, done_nxt, refuse_r, refuse_nxt;
    logic take, allowed, mode_full;

    assign REQ_READY   = (state_r == fspg_pkg::ST_IDLE) && loaded_r;
    assign take        = CE && REQ_VALID && REQ_READY;
    assign mode_full   = (MODE == fspg_pkg::MODE_EXT_TOOL) || (MODE == fspg_pkg::MODE_IN_CIRCUIT_PROG);

    // Admission decision for the request on the port
    always_comb
    begin
        allowed = 1'b0;
        if (unlock_r)
        begin
            unique case (REQ.op)
                fspg_pkg::OP_PROG_OPTION:
                    allowed = mode_full;
                fspg_pkg::OP_ERASE_ALL:
                    allowed = mode_full && !prot_r;
                fspg_pkg::OP_ERASE_SECTOR, fspg_pkg::OP_PROG_BYTE:
                    allowed = dec_hit && !prot_r
                              && (mode_full
                                  || (MODE == fspg_pkg::MODE_IN_APPLICATION_PROG
                                      && dec_sector != 2'h0));
            endcase
        end
    end

    always_comb
    begin
        state_nxt    = state_r;
        cmd_nxt      = cmd_r;
        pend_cmd_nxt = pend_cmd_r;
        pend_nxt     = pend_r;
        key1_nxt     = key1_r;
        unlock_nxt   = unlock_r;
        prot_nxt     = prot_r;
        loaded_nxt   = 1'b1;
        start_nxt    = 1'b0;
        done_nxt     = 1'b0;
        refuse_nxt   = 1'b0;
        if (!loaded_r)
            prot_nxt = READOUT_PROTECT_NV;
        // One unlock is spent on any taken request
        if (take)
            unlock_nxt = 1'b0;
        // Key writes: second key only counts right after the first; set wins over spend
        if (GUARD_WR)
        begin
            key1_nxt = (GUARD_KEY == fspg_pkg::GUARD_KEY1);
            if (key1_r && GUARD_KEY == fspg_pkg::GUARD_KEY2)
                unlock_nxt = 1'b1;
        end
        unique case (state_r)
            fspg_pkg::ST_IDLE:
                if (take)
                begin
                    if (!allowed)
                        refuse_nxt = 1'b1;
                    else
                    begin
                        cmd_nxt   = '{REQ.op, dec_sector, REQ.addr, REQ.data};
                        start_nxt = 1'b1;
                        state_nxt = fspg_pkg::ST_WAIT;
                        // Dropping protection: wipe the array before the option write
                        if (REQ.op == fspg_pkg::OP_PROG_OPTION && prot_r
                            && !REQ.data[fspg_pkg::OPT_PROTECT_BIT])
                        begin
                            pend_cmd_nxt = cmd_nxt;
                            pend_nxt     = 1'b1;
                            cmd_nxt.op   = fspg_pkg::OP_ERASE_ALL;
                        end
                    end
                end
            fspg_pkg::ST_WAIT:
                if (ARR_DONE)
                begin
                    if (pend_r)
                        state_nxt = fspg_pkg::ST_ISSUE;
                    else
                    begin
                        done_nxt  = 1'b1;
                        state_nxt = fspg_pkg::ST_IDLE;
                        if (cmd_r.op == fspg_pkg::OP_PROG_OPTION)
                            prot_nxt = cmd_r.data[fspg_pkg::OPT_PROTECT_BIT];
                    end
                end
            fspg_pkg::ST_ISSUE:
            begin
                cmd_nxt   = pend_cmd_r;
                pend_nxt  = 1'b0;
                start_nxt = 1'b1;
                state_nxt = fspg_pkg::ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_r    <= fspg_pkg::ST_IDLE;
            cmd_r      <= '0;
            pend_cmd_r <= '0;
            pend_r     <= 1'b0;
            key1_r     <= 1'b0;
            unlock_r   <= 1'b0;
            prot_r     <= fspg_pkg::PROTECT_RST;
            loaded_r   <= 1'b0;
            start_r    <= 1'b0;
            done_r     <= 1'b0;
            refuse_r   <= 1'b0;
        end
        else if (CE)
        begin
            state_r    <= state_nxt;
            cmd_r      <= cmd_nxt;
            pend_cmd_r <= pend_cmd_nxt;
            pend_r     <= pend_nxt;
            key1_r     <= key1_nxt;
            unlock_r   <= unlock_nxt;
            prot_r     <= prot_nxt;
            loaded_r   <= loaded_nxt;
            start_r    <= start_nxt;
            done_r     <= done_nxt;
            refuse_r   <= refuse_nxt;
        end
    end

    assign ARR_START   = start_r;
    assign ARR_CMD     = cmd_r;
    assign REQ_DONE    = done_r;
    assign REQ_REFUSED = refuse_r;
    assign UNLOCKED    = unlock_r;
    assign PROTECTED   = prot_r;
    assign EXT_READ_EN = loaded_r && !prot_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_clear_req;
        take && allowed && REQ.op == fspg_pkg::OP_PROG_OPTION && prot_r
            && !REQ.data[fspg_pkg::OPT_PROTECT_BIT];
    endsequence

    sequence s_wipe_then_option;
        (ARR_START && ARR_CMD.op == fspg_pkg::OP_ERASE_ALL)
            ##[1:1000] (ARR_START && ARR_CMD.op == fspg_pkg::OP_PROG_OPTION);
    endsequence

    property p_locked_refused;
        @(posedge SYS_CLK) disable iff (!RSTN)
        take && !unlock_r |=> REQ_REFUSED && !ARR_START;
    endproperty
    a_locked_refused: assert property (p_locked_refused) else $error("locked request not refused");

    property p_iap_sector0;
        @(posedge SYS_CLK) disable iff (!RSTN)
        take && MODE == fspg_pkg::MODE_IN_APPLICATION_PROG && dec_sector == 2'h0
            && REQ.op inside {fspg_pkg::OP_PROG_BYTE, fspg_pkg::OP_ERASE_SECTOR}
            |=> REQ_REFUSED && !ARR_START;
    endproperty
    a_iap_sector0: assert property (p_iap_sector0) else $error("sector 0 written in application mode");

    property p_full_mode_ok;
        @(posedge SYS_CLK) disable iff (!RSTN)
        take && unlock_r && mode_full && !prot_r && dec_hit |=> ARR_START && !REQ_REFUSED;
    endproperty
    a_full_mode_ok: assert property (p_full_mode_ok) else $error("full mode request not issued");

    property p_sector0_range;
        @(posedge SYS_CLK) disable iff (!RSTN)
        REQ.addr[15:12] == 4'hF |-> dec_sector == 2'h0 && dec_hit;
    endproperty
    a_sector0_range: assert property (p_sector0_range) else $error("F000h-FFFFh not sector 0");

    property p_sector_count;
        @(posedge SYS_CLK) disable iff (!RSTN)
        dec_hit |-> (dec_sector == 2'h0 || FLASH_KB > 4) && (dec_sector != 2'h2 || FLASH_KB > 8)
            && (REQ.addr[15:12] != 4'hE || FLASH_KB <= 4 || dec_sector == 2'h1);
    endproperty
    a_sector_count: assert property (p_sector_count) else $error("sector outside array size");

    property p_protect_blocks;
        @(posedge SYS_CLK) disable iff (!RSTN)
        take && prot_r && REQ.op != fspg_pkg::OP_PROG_OPTION |=> REQ_REFUSED ##0 !EXT_READ_EN;
    endproperty
    a_protect_blocks: assert property (p_protect_blocks) else $error("protected array accessed");

    property p_clear_wipes;
        @(posedge SYS_CLK) disable iff (!RSTN)
        s_clear_req |=> s_wipe_then_option;
    endproperty
    a_clear_wipes: assert property (p_clear_wipes) else $error("option cleared without wipe");

    property p_sector_only;
        @(posedge SYS_CLK) disable iff (!RSTN)
        take && allowed && REQ.op == fspg_pkg::OP_ERASE_SECTOR
            |=> ARR_START && ARR_CMD.op == fspg_pkg::OP_ERASE_SECTOR && ARR_CMD.sector == $past(dec_sector);
    endproperty
    a_sector_only: assert property (p_sector_only) else $error("sector erase widened");

endmodule
`default_nettype wire

// >>> verif/fspg_array_model.sv
// Purpose: Behavioural flash array answering the guard's commands
// Assumes: One command at a time, lat of at least 1
// Notes:   Latency comes from the bench so answers can be prompt or slow
`timescale 1ns/100ps
`default_nettype none
module fspg_array_model (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Command side
    input  wire logic                   start,
    input  wire fspg_pkg::fspg_cmd_type cmd,
    input  wire logic [3:0]             lat,
    output logic                        done,
    // Observation
    output int                          n_start,
    output fspg_pkg::fspg_op_type       last_op
);
    logic [3:0] cnt_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r   <= 4'h0;
            done    <= 1'b0;
            n_start <= 0;
            last_op <= fspg_pkg::OP_PROG_BYTE;
        end
        else
        begin
            // Done never coincides with start, so the guard sees it while waiting
            done <= (cnt_r == 4'h1);
            if (start)
            begin
                cnt_r   <= lat;
                n_start <= n_start + 1;
                last_op <= cmd.op;
            end
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verif/fspg_guard_test.sv
// Purpose: Self-checking bench for the flash sector program guard
// Assumes: 60K array, so the array starts at 1000h
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module fspg_guard_test;
    logic                    clk = 1'b0;
    logic                    rstn = 1'b0;
    logic                    ce = 1'b1;
    fspg_pkg::fspg_mode_type mode = fspg_pkg::MODE_NONE;
    logic                    nv = 1'b0;
    logic                    guard_wr = 1'b0;
    logic [7:0]              guard_key = 8'h00;
    logic                    req_valid = 1'b0;
    fspg_pkg::fspg_req_type  req = '0;
    logic                    req_ready, req_done, req_refused, arr_start, arr_done;
    fspg_pkg::fspg_cmd_type  arr_cmd;
    logic                    unlocked, prot, ext_rd;
    logic [3:0]              lat = 4'h1;
    int                      n_start;
    fspg_pkg::fspg_op_type   last_op;
    int                      n_mismatch = 0;
    int                      n_tests = 0;

    fspg_guard #(.FLASH_KB(60)) fspg_guard_inst (.SYS_CLK(clk), .RSTN(rstn), .CE(ce), .MODE(mode),
        .READOUT_PROTECT_NV(nv), .GUARD_WR(guard_wr), .GUARD_KEY(guard_key), .REQ_VALID(req_valid),
        .REQ(req), .REQ_READY(req_ready), .REQ_DONE(req_done), .REQ_REFUSED(req_refused),
        .ARR_START(arr_start), .ARR_CMD(arr_cmd), .ARR_DONE(arr_done), .UNLOCKED(unlocked),
        .PROTECTED(prot), .EXT_READ_EN(ext_rd));

    fspg_array_model fspg_array_model_inst (.clk(clk), .rstn(rstn), .start(arr_start), .cmd(arr_cmd),
        .lat(lat), .done(arr_done), .n_start(n_start), .last_op(last_op));

    initial
    begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask

    task automatic results;
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic prot_nv);
        rstn = 1'b0;
        nv = prot_nv;
        repeat (16) @(negedge clk);
        chk("ready in reset", 28'(req_ready), 28'h0);
        chk("protect in reset", 28'({unlocked, prot, ext_rd}), 28'h2);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        chk("protect loaded", 28'({prot, ext_rd}), 28'({prot_nv, !prot_nv}));
    endtask

    task automatic unlock;
        guard_wr = 1'b1;
        guard_key = fspg_pkg::GUARD_KEY1;
        @(negedge clk);
        guard_key = fspg_pkg::GUARD_KEY2;
        @(negedge clk);
        guard_wr = 1'b0;
        chk("unlocked", 28'(unlocked), 28'h1);
    endtask

    // Runs one request; first is the op expected on the first array command
    task automatic do_req(input logic unl, input fspg_pkg::fspg_op_type op, input logic [15:0] a,
                          input logic [7:0] d, input logic ok, input logic [1:0] sec,
                          input fspg_pkg::fspg_op_type first);
        int n;
        int n0;
        n = 0;
        n0 = n_start;
        if (unl)
            unlock();
        req_valid = 1'b1;
        req = '{op, a, d};
        @(negedge clk);
        req_valid = 1'b0;
        chk("refused", 28'(req_refused), 28'(!ok));
        chk("start", 28'(arr_start), 28'(ok));
        chk("unlock spent", 28'(unlocked), 28'h0);
        if (ok && op == first)
            chk("cmd", 28'({arr_cmd.op, arr_cmd.sector}), 28'({op, sec}));
        if (ok && op == fspg_pkg::OP_PROG_BYTE)
            chk("byte cmd", arr_cmd, {op, sec, a, d});
        if (ok && op != first)
            chk("first op", 28'(arr_cmd.op), 28'(first));
        while (ok && req_done !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        if (ok)
            chk("done", 28'({req_done, req_ready}), 28'h3);
        chk("commands", 28'(n_start - n0), 28'(ok ? (op == first ? 1 : 2) : 0));
        if (ok)
            chk("last op", 28'(last_op), 28'(op));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_locked;
        mode = fspg_pkg::MODE_IN_CIRCUIT_PROG;
        do_req(1'b0, fspg_pkg::OP_PROG_BYTE, 16'hE000, 8'h11, 1'b0, 2'h1, fspg_pkg::OP_PROG_BYTE);
        $display("test locked finished");
    endtask

    task automatic t_tool;
        for (int m = 1; m < 3; m++)
        begin
            mode = fspg_pkg::fspg_mode_type'(m);
            lat = 4'(m * 3);
            do_req(1'b1, fspg_pkg::OP_ERASE_ALL, 16'h1000, 8'h00, 1'b1, 2'h2, fspg_pkg::OP_ERASE_ALL);
            do_req(1'b1, fspg_pkg::OP_ERASE_SECTOR, 16'hF000, 8'h00, 1'b1, 2'h0,
                   fspg_pkg::OP_ERASE_SECTOR);
            do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'hFFFF, 8'hA5, 1'b1, 2'h0, fspg_pkg::OP_PROG_BYTE);
            do_req(1'b1, fspg_pkg::OP_PROG_OPTION, 16'h0000, 8'h00, 1'b1, 2'h2, fspg_pkg::OP_PROG_OPTION);
        end
        $display("test tool modes finished");
    endtask

    task automatic t_iap;
        mode = fspg_pkg::MODE_IN_APPLICATION_PROG;
        lat = 4'h8;
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'hF000, 8'h3C, 1'b0, 2'h0, fspg_pkg::OP_PROG_BYTE);
        do_req(1'b1, fspg_pkg::OP_ERASE_SECTOR, 16'hFFFF, 8'h00, 1'b0, 2'h0, fspg_pkg::OP_ERASE_SECTOR);
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'hEFFF, 8'h96, 1'b1, 2'h1, fspg_pkg::OP_PROG_BYTE);
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'hE000, 8'h5A, 1'b1, 2'h1, fspg_pkg::OP_PROG_BYTE);
        do_req(1'b1, fspg_pkg::OP_ERASE_SECTOR, 16'hDFFF, 8'h00, 1'b1, 2'h2, fspg_pkg::OP_ERASE_SECTOR);
        do_req(1'b1, fspg_pkg::OP_ERASE_ALL, 16'h1000, 8'h00, 1'b0, 2'h2, fspg_pkg::OP_ERASE_ALL);
        $display("test in-application finished");
    endtask

    task automatic t_bounds;
        mode = fspg_pkg::MODE_NONE;
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'hE000, 8'h01, 1'b0, 2'h1, fspg_pkg::OP_PROG_BYTE);
        mode = fspg_pkg::MODE_IN_CIRCUIT_PROG;
        lat = 4'h1;
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'h0FFF, 8'h02, 1'b0, 2'h2, fspg_pkg::OP_PROG_BYTE);
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'h1000, 8'h03, 1'b1, 2'h2, fspg_pkg::OP_PROG_BYTE);
        $display("test bounds finished");
    endtask

    // A request held while the clock enable is low must not be taken, nor spend the unlock
    task automatic t_ce;
        int n0;
        n0 = n_start;
        mode = fspg_pkg::MODE_IN_CIRCUIT_PROG;
        lat = 4'h1;
        unlock();
        ce = 1'b0;
        req_valid = 1'b1;
        req = '{fspg_pkg::OP_PROG_BYTE, 16'h2000, 8'h44};
        repeat (3) @(negedge clk);
        chk("frozen", 28'({arr_start, req_refused, unlocked}), 28'h1);
        chk("frozen commands", 28'(n_start - n0), 28'h0);
        ce = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        chk("start after freeze", 28'({arr_start, unlocked}), 28'h2);
        repeat (3) @(negedge clk);
        chk("done after freeze", 28'({req_done, req_ready}), 28'h3);
        chk("commands after freeze", 28'(n_start - n0), 28'h1);
        $display("test clock enable finished");
    endtask

    task automatic t_protect;
        do_reset(1'b1);
        mode = fspg_pkg::MODE_IN_CIRCUIT_PROG;
        lat = 4'h2;
        do_req(1'b1, fspg_pkg::OP_PROG_BYTE, 16'hE000, 8'h77, 1'b0, 2'h1, fspg_pkg::OP_PROG_BYTE);
        do_req(1'b1, fspg_pkg::OP_ERASE_ALL, 16'h1000, 8'h00, 1'b0, 2'h2, fspg_pkg::OP_ERASE_ALL);
        do_req(1'b1, fspg_pkg::OP_PROG_OPTION, 16'h0000, 8'h00, 1'b1, 2'h0, fspg_pkg::OP_ERASE_ALL);
        @(negedge clk);
        chk("protect cleared", 28'({prot, ext_rd}), 28'h1);
        do_req(1'b1, fspg_pkg::OP_PROG_OPTION, 16'h0000, 8'h01, 1'b1, 2'h2, fspg_pkg::OP_PROG_OPTION);
        chk("protect set", 28'({prot, ext_rd}), 28'h2);
        $display("test protection finished");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end

    initial
    begin
        do_reset(1'b0);
        t_locked();
        t_tool();
        t_iap();
        t_bounds();
        t_ce();
        t_protect();
        results();
    end
endmodule
`default_nettype wire
